/* File: hdl/lvds_link_pkg.sv */
package lvds_link_pkg;
    localparam int NUM_PORTS = 2;
    localparam int LANES = 4;
    localparam int WORD_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_PERIOD_NS = 10;
    // half period of the link clock that a transmitter makes
    localparam int LINK_HALF_NS = 60;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_LOAD = 8'(LINK_HALF_CYC - 1);
    // gap between words lets a withdrawn permit arrive before the next word
    localparam int GAP_NS = 60;
    localparam logic [7:0] GAP_LOAD = 8'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    localparam int STRAP_PORT = 1;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // receive lane bit positions after synchronising
    localparam int RX_CLK_BIT = 4;
    localparam int RX_DONE_BIT = 5;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LOW = 2'b01,
        TX_HIGH = 2'b10,
        TX_GAP = 2'b11
    } tx_state_e;
endpackage : lvds_link_pkg

/* File: hdl/lvds_link_if.sv */
`timescale 1ns/10ps
interface lvds_link_if #(parameter int NP = lvds_link_pkg::NUM_PORTS);
    // device to far end, plus the permit back from the far end
    logic [NP-1:0][3:0] link_tx_data_pos;
    logic [NP-1:0][3:0] link_tx_data_neg;
    logic [NP-1:0] link_tx_clock_pos;
    logic [NP-1:0] link_tx_clock_neg;
    logic [NP-1:0] link_tx_block_done_out;
    logic [NP-1:0] link_tx_block_done_oe;
    logic [NP-1:0] link_tx_permit_in;
    // far end to device, plus the permit back from the device
    logic [NP-1:0][3:0] link_rx_data_pos;
    logic [NP-1:0][3:0] link_rx_data_neg;
    logic [NP-1:0] link_rx_clock_pos;
    logic [NP-1:0] link_rx_clock_neg;
    logic [NP-1:0] link_rx_block_done_in;
    logic [NP-1:0] link_rx_permit_out;
    // strap level the board puts on an undriven done pin
    logic [NP-1:0] port_one_block_done_strap;
    logic [NP-1:0] link_tx_block_done_pin;

    assign link_tx_block_done_pin = (link_tx_block_done_oe & link_tx_block_done_out)
        | (~link_tx_block_done_oe & port_one_block_done_strap);

    modport device (
        output link_tx_data_pos, link_tx_data_neg, link_tx_clock_pos, link_tx_clock_neg,
        output link_tx_block_done_out, link_tx_block_done_oe, link_rx_permit_out,
        input link_tx_permit_in, link_tx_block_done_pin,
        input link_rx_data_pos, link_rx_data_neg, link_rx_clock_pos, link_rx_clock_neg,
        input link_rx_block_done_in
    );
    modport far (
        output link_rx_data_pos, link_rx_data_neg, link_rx_clock_pos, link_rx_clock_neg,
        output link_rx_block_done_in, link_tx_permit_in,
        input link_tx_data_pos, link_tx_data_neg, link_tx_clock_pos, link_tx_clock_neg,
        input link_tx_block_done_pin, link_rx_permit_out
    );
endinterface : lvds_link_if

/* File: hdl/lvds_link_device.sv */
`timescale 1ns/10ps
module link_fifo #(
    parameter int W = 9,
    parameter int D = lvds_link_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D+1)-1:0] count
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("link_fifo depth must be a power of two, at least 2");
    end
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW-1:0] next_wr;
    logic [AW-1:0] next_rd;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;
    logic next_in_ready;
    logic next_out_valid;
    logic [W-1:0] next_out_data;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr = push ? wr + 1'b1 : wr;
        next_rd = pop ? rd + 1'b1 : rd;
        next_count = count + CW'(push) - CW'(pop);
        next_in_ready = (next_count != CW'(D));
        next_out_valid = (next_count != '0);
        next_out_data = (push && next_rd == wr) ? in_data : mem[next_rd];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr <= '0;
            rd <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr <= next_wr;
            rd <= next_rd;
            count <= next_count;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr] <= in_data;
        end
    end
endmodule : link_fifo

module link_tx_engine #(
    parameter int W = lvds_link_pkg::WORD_W,
    parameter int D = lvds_link_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user words
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    input wire logic in_last,
    // link pins
    input wire logic permit_raw,
    output logic [3:0] data_pos,
    output logic [3:0] data_neg,
    output logic clk_pos,
    output logic clk_neg,
    output logic done
);
    localparam logic [3:0] NIB_LAST = 4'(W / lvds_link_pkg::LANES - 1);
    if (W < 8 || W % lvds_link_pkg::LANES != 0 || W > 64) begin : g_bad_width
        $error("link word must be 8 to 64 bits in whole nibbles");
    end
    lvds_link_pkg::tx_state_e state;
    lvds_link_pkg::tx_state_e next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [3:0] nib;
    logic [3:0] next_nib;
    logic [W-1:0] word;
    logic [W-1:0] next_word;
    logic [3:0] next_data;
    logic next_clk;
    logic next_done;
    logic permit_s1;
    logic permit_s2;
    logic f_valid;
    logic pop;
    logic [W:0] f_word;

    link_fifo #(.W(W + 1), .D(D)) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({in_last, in_data}),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_word),
        .count()
    );

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_nib = nib;
        next_word = word;
        next_data = data_pos;
        next_clk = clk_pos;
        next_done = done;
        pop = 1'b0;
        case (state)
            lvds_link_pkg::TX_IDLE: begin
                if (f_valid && permit_s2) begin
                    pop = 1'b1;
                    next_word = f_word[W-1:0];
                    next_data = f_word[3:0];
                    next_done = f_word[W];
                    next_nib = '0;
                    next_cnt = lvds_link_pkg::HALF_LOAD;
                    next_state = lvds_link_pkg::TX_LOW;
                end
            end
            lvds_link_pkg::TX_LOW: begin
                if (cnt == '0) begin
                    next_clk = 1'b1;
                    next_cnt = lvds_link_pkg::HALF_LOAD;
                    next_state = lvds_link_pkg::TX_HIGH;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            lvds_link_pkg::TX_HIGH: begin
                if (cnt == '0) begin
                    next_clk = 1'b0;
                    if (nib == NIB_LAST) begin
                        next_done = 1'b0;
                        next_cnt = lvds_link_pkg::GAP_LOAD;
                        next_state = lvds_link_pkg::TX_GAP;
                    end else begin
                        next_nib = nib + 4'h1;
                        next_word = {4'h0, word[W-1:4]};
                        next_data = word[7:4];
                        next_cnt = lvds_link_pkg::HALF_LOAD;
                        next_state = lvds_link_pkg::TX_LOW;
                    end
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            lvds_link_pkg::TX_GAP: begin
                if (cnt == '0) begin
                    next_state = lvds_link_pkg::TX_IDLE;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            default: next_state = lvds_link_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= lvds_link_pkg::TX_IDLE;
            cnt <= '0;
            nib <= '0;
            word <= '0;
            data_pos <= 4'h0;
            data_neg <= 4'hf;
            clk_pos <= 1'b0;
            clk_neg <= 1'b1;
            done <= 1'b0;
            permit_s1 <= 1'b0;
            permit_s2 <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            nib <= next_nib;
            word <= next_word;
            data_pos <= next_data;
            data_neg <= ~next_data;
            clk_pos <= next_clk;
            clk_neg <= ~next_clk;
            done <= next_done;
            permit_s1 <= permit_raw;
            permit_s2 <= permit_s1;
        end
    end
endmodule : link_tx_engine

module link_rx_engine #(
    parameter int W = lvds_link_pkg::WORD_W,
    parameter int D = lvds_link_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link pins
    input wire logic [3:0] data_pos,
    input wire logic [3:0] data_neg,
    input wire logic clk_pos,
    input wire logic clk_neg,
    input wire logic done_raw,
    output logic permit,
    // user words
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic out_last
);
    localparam logic [3:0] NIB_LAST = 4'(W / lvds_link_pkg::LANES - 1);
    localparam int CW = $clog2(D+1);
    // one slot kept back for a word already under way
    localparam logic [CW:0] PERMIT_MAX = (CW+1)'(D - 1);
    logic [5:0] raw;
    logic [5:0] s1;
    logic [5:0] s2;
    logic clk_d;
    logic rise;
    logic [3:0] nib;
    logic [3:0] next_nib;
    logic [W-1:0] word;
    logic [W-1:0] next_word;
    logic push;
    logic next_push;
    logic [W:0] pdata;
    logic [W:0] next_pdata;
    logic next_permit;
    logic in_ready;
    logic [CW-1:0] count;

    assign raw = {done_raw, clk_pos & ~clk_neg, data_pos & ~data_neg};

    link_fifo #(.W(W + 1), .D(D)) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data(pdata),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_last, out_data}),
        .count(count)
    );

    always_comb begin
        rise = s2[lvds_link_pkg::RX_CLK_BIT] && !clk_d;
        next_nib = nib;
        next_word = word;
        next_push = 1'b0;
        next_pdata = pdata;
        if (rise) begin
            next_word = {s2[3:0], word[W-1:4]};
            if (nib == NIB_LAST) begin
                next_nib = '0;
                next_push = 1'b1;
                next_pdata = {s2[lvds_link_pkg::RX_DONE_BIT], s2[3:0], word[W-1:4]};
            end else begin
                next_nib = nib + 4'h1;
            end
        end
        next_permit = in_ready && (({1'b0, count} + (CW+1)'(push)) < PERMIT_MAX);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            clk_d <= 1'b0;
            nib <= '0;
            word <= '0;
            push <= 1'b0;
            pdata <= '0;
            permit <= 1'b0;
        end else begin
            // link clock crosses by two flops
            s1 <= raw;
            s2 <= s1;
            clk_d <= s2[lvds_link_pkg::RX_CLK_BIT];
            nib <= next_nib;
            word <= next_word;
            push <= next_push;
            pdata <= next_pdata;
            permit <= next_permit;
        end
    end
endmodule : link_rx_engine

module lvds_link_device #(
    parameter int NP = lvds_link_pkg::NUM_PORTS,
    parameter int W = lvds_link_pkg::WORD_W,
    parameter int D = lvds_link_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // link
    lvds_link_if.device LINK,
    // transmit words
    input wire logic [NP-1:0] TX_VALID,
    output logic [NP-1:0] TX_READY,
    input wire logic [NP-1:0][W-1:0] TX_DATA,
    input wire logic [NP-1:0] TX_LAST,
    // receive words
    output logic [NP-1:0] RX_VALID,
    input wire logic [NP-1:0] RX_READY,
    output logic [NP-1:0][W-1:0] RX_DATA,
    output logic [NP-1:0] RX_LAST,
    // strap
    output logic STRAP_VALUE,
    output logic STRAP_VALID
);
    if (NP <= lvds_link_pkg::STRAP_PORT) begin : g_bad_ports
        $error("lvds_link_device needs the strap port");
    end
    logic strap_s1;
    logic strap_s2;
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic next_strap_value;
    logic next_strap_valid;
    logic [NP-1:0] next_oe;

    for (genvar p = 0; p < NP; p++) begin : g_port
        link_tx_engine #(.W(W), .D(D)) u_tx (
            .clk(CLK),
            .rst(RST),
            .in_valid(TX_VALID[p]),
            .in_ready(TX_READY[p]),
            .in_data(TX_DATA[p]),
            .in_last(TX_LAST[p]),
            .permit_raw(LINK.link_tx_permit_in[p]),
            .data_pos(LINK.link_tx_data_pos[p]),
            .data_neg(LINK.link_tx_data_neg[p]),
            .clk_pos(LINK.link_tx_clock_pos[p]),
            .clk_neg(LINK.link_tx_clock_neg[p]),
            .done(LINK.link_tx_block_done_out[p])
        );
        link_rx_engine #(.W(W), .D(D)) u_rx (
            .clk(CLK),
            .rst(RST),
            .data_pos(LINK.link_rx_data_pos[p]),
            .data_neg(LINK.link_rx_data_neg[p]),
            .clk_pos(LINK.link_rx_clock_pos[p]),
            .clk_neg(LINK.link_rx_clock_neg[p]),
            .done_raw(LINK.link_rx_block_done_in[p]),
            .permit(LINK.link_rx_permit_out[p]),
            .out_valid(RX_VALID[p]),
            .out_ready(RX_READY[p]),
            .out_data(RX_DATA[p]),
            .out_last(RX_LAST[p])
        );
    end

    always_comb begin
        next_settle = settle;
        next_strap_value = STRAP_VALUE;
        next_strap_valid = STRAP_VALID;
        next_oe = {NP{1'b1}};
        // pin stays undriven until strap caught
        if (!STRAP_VALID) begin
            next_oe[lvds_link_pkg::STRAP_PORT] = 1'b0;
            if (settle == lvds_link_pkg::STRAP_SETTLE) begin
                next_strap_value = strap_s2;
                next_strap_valid = 1'b1;
                next_oe[lvds_link_pkg::STRAP_PORT] = 1'b1;
            end else begin
                next_settle = settle + 2'h1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            settle <= '0;
            STRAP_VALUE <= 1'b0;
            STRAP_VALID <= 1'b0;
            LINK.link_tx_block_done_oe <= '0;
        end else begin
            strap_s1 <= LINK.link_tx_block_done_pin[lvds_link_pkg::STRAP_PORT];
            strap_s2 <= strap_s1;
            settle <= next_settle;
            STRAP_VALUE <= next_strap_value;
            STRAP_VALID <= next_strap_valid;
            LINK.link_tx_block_done_oe <= next_oe;
        end
    end
endmodule : lvds_link_device

/* File: hdl/lvds_link_far.sv */
`timescale 1ns/10ps
module lvds_link_far #(
    parameter int NP = lvds_link_pkg::NUM_PORTS,
    parameter int W = lvds_link_pkg::WORD_W,
    parameter int D = lvds_link_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // link
    lvds_link_if.far LINK,
    // words toward the device
    input wire logic [NP-1:0] TX_VALID,
    output logic [NP-1:0] TX_READY,
    input wire logic [NP-1:0][W-1:0] TX_DATA,
    input wire logic [NP-1:0] TX_LAST,
    // words from the device
    output logic [NP-1:0] RX_VALID,
    input wire logic [NP-1:0] RX_READY,
    output logic [NP-1:0][W-1:0] RX_DATA,
    output logic [NP-1:0] RX_LAST
);
    // far end has the mirrored duties: it honours the device permit
    for (genvar p = 0; p < NP; p++) begin : g_port
        link_tx_engine #(.W(W), .D(D)) u_tx (
            .clk(CLK),
            .rst(RST),
            .in_valid(TX_VALID[p]),
            .in_ready(TX_READY[p]),
            .in_data(TX_DATA[p]),
            .in_last(TX_LAST[p]),
            .permit_raw(LINK.link_rx_permit_out[p]),
            .data_pos(LINK.link_rx_data_pos[p]),
            .data_neg(LINK.link_rx_data_neg[p]),
            .clk_pos(LINK.link_rx_clock_pos[p]),
            .clk_neg(LINK.link_rx_clock_neg[p]),
            .done(LINK.link_rx_block_done_in[p])
        );
        link_rx_engine #(.W(W), .D(D)) u_rx (
            .clk(CLK),
            .rst(RST),
            .data_pos(LINK.link_tx_data_pos[p]),
            .data_neg(LINK.link_tx_data_neg[p]),
            .clk_pos(LINK.link_tx_clock_pos[p]),
            .clk_neg(LINK.link_tx_clock_neg[p]),
            .done_raw(LINK.link_tx_block_done_pin[p]),
            .permit(LINK.link_tx_permit_in[p]),
            .out_valid(RX_VALID[p]),
            .out_ready(RX_READY[p]),
            .out_data(RX_DATA[p]),
            .out_last(RX_LAST[p])
        );
    end
endmodule : lvds_link_far

/* File: bench/lvds_link_chk.sv */
`timescale 1ns/10ps
module lvds_link_chk #(
    parameter int NP = 2
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // device to far end, plus the permit back from the far end
    input wire logic [NP-1:0][3:0] link_tx_data_pos,
    input wire logic [NP-1:0][3:0] link_tx_data_neg,
    input wire logic [NP-1:0] link_tx_clock_pos,
    input wire logic [NP-1:0] link_tx_clock_neg,
    input wire logic [NP-1:0] link_tx_block_done_out,
    input wire logic [NP-1:0] link_tx_block_done_oe,
    input wire logic [NP-1:0] link_tx_permit_in,
    // far end to device, plus the permit back from the device
    input wire logic [NP-1:0][3:0] link_rx_data_pos,
    input wire logic [NP-1:0][3:0] link_rx_data_neg,
    input wire logic [NP-1:0] link_rx_clock_pos,
    input wire logic [NP-1:0] link_rx_clock_neg,
    input wire logic [NP-1:0] link_rx_block_done_in,
    input wire logic [NP-1:0] link_rx_permit_out
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // each high half of a forwarded clock lasts six core cycles, each low half at least six
    sequence half_high(c);
        c [*6] ##1 !c;
    endsequence
    sequence half_low(c);
        !c [*6];
    endsequence
    // port one stays off its done pin while the strap settles
    sequence strap_settle;
        !link_tx_block_done_oe[1] [*3] ##[1:4] link_tx_block_done_oe[1];
    endsequence

    strap_hold_a: assert property ($fell(RST) |-> strap_settle)
        else $error("port one done pin driven during strap settle");

    for (genvar p = 0; p < NP; p++) begin : g_port
        // 40 cycles covers sync delay plus one word that may already be under way
        logic [5:0] tx_low_cnt;
        logic [5:0] rx_low_cnt;
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                tx_low_cnt <= 6'h0;
                rx_low_cnt <= 6'h0;
            end else begin
                tx_low_cnt <= link_tx_permit_in[p] ? 6'h0 : tx_low_cnt + 6'(tx_low_cnt != 6'h3f);
                rx_low_cnt <= link_rx_permit_out[p] ? 6'h0 : rx_low_cnt + 6'(rx_low_cnt != 6'h3f);
            end
        end
        tx_diff_a: assert property ({link_tx_data_neg[p], link_tx_clock_neg[p]} == ~{link_tx_data_pos[p], link_tx_clock_pos[p]})
            else $error("tx pair not complementary");
        rx_diff_a: assert property ({link_rx_data_neg[p], link_rx_clock_neg[p]} == ~{link_rx_data_pos[p], link_rx_clock_pos[p]})
            else $error("rx pair not complementary");
        tx_half_a: assert property ($rose(link_tx_clock_pos[p]) |-> half_high(link_tx_clock_pos[p]))
            else $error("tx clock high phase wrong");
        tx_low_a: assert property ($fell(link_tx_clock_pos[p]) |-> half_low(link_tx_clock_pos[p]))
            else $error("tx clock low phase too short");
        rx_half_a: assert property ($rose(link_rx_clock_pos[p]) |-> half_high(link_rx_clock_pos[p]))
            else $error("rx clock high phase wrong");
        tx_hold_a: assert property (link_tx_clock_pos[p] |-> $stable(link_tx_data_pos[p]))
            else $error("tx lanes moved while clock high");
        rx_hold_a: assert property (link_rx_clock_pos[p] |-> $stable(link_rx_data_pos[p]))
            else $error("rx lanes moved while clock high");
        tx_done_a: assert property ($changed(link_tx_block_done_out[p]) |-> !link_tx_clock_pos[p])
            else $error("tx block done moved while clock high");
        rx_done_a: assert property ($changed(link_rx_block_done_in[p]) |-> !link_rx_clock_pos[p])
            else $error("rx block done moved while clock high");
        tx_stop_a: assert property (tx_low_cnt >= 6'h28 |-> !$rose(link_tx_clock_pos[p]))
            else $error("device sent without permit");
        rx_stop_a: assert property (rx_low_cnt >= 6'h28 |-> !$rose(link_rx_clock_pos[p]))
            else $error("far end sent without permit");
    end
endmodule : lvds_link_chk

/* File: bench/lvds_link_port_handshake_test.sv */
`timescale 1ns/10ps
module lvds_link_port_handshake_test;
    logic clk;
    logic rst;
    logic stall;
    logic [1:0] tx_valid [2];
    logic [1:0] tx_ready [2];
    logic [1:0][7:0] tx_data [2];
    logic [1:0] tx_last [2];
    logic [1:0] rx_valid [2];
    logic [1:0] rx_ready [2];
    logic [1:0][7:0] rx_data [2];
    logic [1:0] rx_last [2];
    logic strap_value;
    logic strap_valid;
    logic [8:0] exp_q [4][$];
    int seed = 19126;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    lvds_link_if lvds_link_if_i ();
    lvds_link_device lvds_link_device_i (
        .CLK(clk), .RST(rst), .LINK(lvds_link_if_i.device),
        .TX_VALID(tx_valid[0]), .TX_READY(tx_ready[0]), .TX_DATA(tx_data[0]), .TX_LAST(tx_last[0]),
        .RX_VALID(rx_valid[0]), .RX_READY(rx_ready[0]), .RX_DATA(rx_data[0]), .RX_LAST(rx_last[0]),
        .STRAP_VALUE(strap_value), .STRAP_VALID(strap_valid)
    );
    lvds_link_far lvds_link_far_i (
        .CLK(clk), .RST(rst), .LINK(lvds_link_if_i.far),
        .TX_VALID(tx_valid[1]), .TX_READY(tx_ready[1]), .TX_DATA(tx_data[1]), .TX_LAST(tx_last[1]),
        .RX_VALID(rx_valid[1]), .RX_READY(rx_ready[1]), .RX_DATA(rx_data[1]), .RX_LAST(rx_last[1])
    );
    lvds_link_chk lvds_link_chk_i (
        .CLK(clk), .RST(rst),
        .link_tx_data_pos(lvds_link_if_i.link_tx_data_pos), .link_tx_data_neg(lvds_link_if_i.link_tx_data_neg),
        .link_tx_clock_pos(lvds_link_if_i.link_tx_clock_pos), .link_tx_clock_neg(lvds_link_if_i.link_tx_clock_neg),
        .link_tx_block_done_out(lvds_link_if_i.link_tx_block_done_out),
        .link_tx_block_done_oe(lvds_link_if_i.link_tx_block_done_oe),
        .link_tx_permit_in(lvds_link_if_i.link_tx_permit_in),
        .link_rx_data_pos(lvds_link_if_i.link_rx_data_pos), .link_rx_data_neg(lvds_link_if_i.link_rx_data_neg),
        .link_rx_clock_pos(lvds_link_if_i.link_rx_clock_pos), .link_rx_clock_neg(lvds_link_if_i.link_rx_clock_neg),
        .link_rx_block_done_in(lvds_link_if_i.link_rx_block_done_in),
        .link_rx_permit_out(lvds_link_if_i.link_rx_permit_out)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic void check(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endfunction

    // first two words are all-zero and all-one, the second always closing a block
    function automatic logic [8:0] make_word(input int i, input int n);
        logic [7:0] d;
        d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
        return {i == 1 || i == n - 1 || ($random(seed) & 3) == 0, d};
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            conclude();
        end
    end

    // receivers pop at random; one port per end freezes while stalled
    always @(posedge clk) begin
        #1;
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 2; p++) begin
                rx_ready[r][p] = (stall && r + p == 1) ? 1'b0 : (($random(seed) & 3) != 0);
            end
        end
    end

    // a word seen valid and ready here is popped at the next rising edge
    always @(negedge clk) begin
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 2; p++) begin
                if (rst === 1'b0 && rx_valid[r][p] === 1'b1 && rx_ready[r][p] === 1'b1) begin
                    logic [8:0] w;
                    w = 9'hxxx;
                    if (exp_q[(1 - r) * 2 + p].size() != 0) begin
                        w = exp_q[(1 - r) * 2 + p].pop_front();
                    end
                    check({rx_last[r][p], rx_data[r][p]}, w, "received word");
                end
            end
        end
    end

    task automatic stream(input int e, input int p, input int n, input logic gaps);
        logic [8:0] w;
        int k;
        @(posedge clk);
        #1;
        for (int i = 0; i < n; i++) begin
            w = make_word(i, n);
            if (gaps && ($random(seed) & 7) == 0) begin
                tx_valid[e][p] = 1'b0;
                repeat (3) @(posedge clk);
                #1;
            end
            tx_data[e][p] = w[7:0];
            tx_last[e][p] = w[8];
            tx_valid[e][p] = 1'b1;
            k = 0;
            @(negedge clk);
            while (tx_ready[e][p] !== 1'b1 && k < 3000) begin
                @(negedge clk);
                k++;
            end
            exp_q[e * 2 + p].push_back(w);
            @(posedge clk);
            #1;
        end
        tx_valid[e][p] = 1'b0;
    endtask : stream

    task automatic drain();
        int k;
        int left;
        k = 0;
        left = 1;
        while (left != 0 && k < 3000) begin
            @(negedge clk);
            left = exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size();
            k++;
        end
        repeat (4) @(negedge clk);
        check(9'(left), 9'h0, "words undelivered");
        check(9'({rx_valid[0], rx_valid[1]}), 9'h0, "receive buffers not empty");
    endtask : drain

    task automatic do_reset(input logic s);
        int k;
        @(posedge clk);
        #1;
        lvds_link_if_i.port_one_block_done_strap = {s, s};
        rst = 1'b1;
        repeat (2) @(posedge clk);
        check(9'(lvds_link_if_i.link_rx_permit_out | lvds_link_if_i.link_tx_permit_in), 9'h0, "permit in reset");
        #1;
        rst = 1'b0;
        k = 0;
        while (strap_valid !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        check(9'({strap_valid, strap_value}), 9'({1'b1, s}), "strap level");
    endtask : do_reset

    initial begin
        rst = 1'b1;
        stall = 1'b0;
        for (int e = 0; e < 2; e++) begin
            tx_valid[e] = 2'h0;
            tx_data[e] = 16'h0;
            tx_last[e] = 2'h0;
            rx_ready[e] = 2'h3;
        end
        // both directions, both ports, with random gaps and pops
        do_reset(1'b0);
        fork
            stream(0, 0, 20, 1'b1);
            stream(0, 1, 20, 1'b1);
            stream(1, 0, 20, 1'b1);
            stream(1, 1, 20, 1'b1);
        join
        drain();
        // reset again mid-run; one receiver per end stalls so both senders must fill and refuse
        do_reset(1'b1);
        stall = 1'b1;
        fork
            stream(0, 0, 14, 1'b0);
            stream(1, 1, 14, 1'b0);
        join_none
        repeat (600) @(negedge clk);
        check(9'({tx_ready[0][0], tx_ready[1][1]}), 9'h0, "tx buffer still ready");
        check(9'({lvds_link_if_i.link_tx_permit_in[0], lvds_link_if_i.link_rx_permit_out[1]}), 9'h0, "permit kept");
        stall = 1'b0;
        wait fork;
        drain();
        conclude();
    end
endmodule : lvds_link_port_handshake_test
